// *** rtl/cbt_bit_timing.sv ***
/*
  CAN bit timing: two configuration registers, quantum generation, bit segment
  sequencing with resynchronisation, and single or triple sampling of the bus.
  Assumes rx_level is already synchronous to clk_sys (1 = recessive) and that the
  phase-2 length field of the third timing register arrives on its own input.
*/
// How it works
// - Jump width equals the two-bit field plus one quanta, one to four.
// - One quantum lasts twice the prescaler plus two oscillator periods.
// - Select bit one: phase 2 length comes from the third register field.
// - Select bit zero: phase 2 is the larger of phase 1 and two quanta.
// - Sampling bit one takes three samples per bit; zero takes one.
// - Phase 1 lasts its three-bit field plus one quanta, bits five to three.
// - Propagation lasts its three-bit field plus one quanta, bits two to zero.
// - Both timing registers are fully readable, writable and reset to zero.
`timescale 1ns/1ps
module cbt_bit_timing #(
  parameter int PRESC_W = 6
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire cbt_pkg::cbt_reg_req_s reg_req,
  output logic [cbt_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [cbt_pkg::SEG_W-1:0] phase2_length_field,
  input wire logic rx_level,
  output logic tq_pulse,
  output logic bit_start,
  output logic sample_pulse,
  output logic rx_bit,
  output cbt_pkg::cbt_seg_e seg_state
);
  import cbt_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  function automatic logic [QCNT_W-1:0] max_q(input logic [QCNT_W-1:0] a,
                                              input logic [QCNT_W-1:0] b);
    max_q = (a > b) ? a : b;
  endfunction : max_q

  function automatic logic [QCNT_W-1:0] min_q(input logic [QCNT_W-1:0] a,
                                              input logic [QCNT_W-1:0] b);
    min_q = (a < b) ? a : b;
  endfunction : min_q

  function automatic logic [QCNT_W-1:0] field_plus_one(input logic [SEG_W-1:0] f);
    field_plus_one = QCNT_W'({2'b00, f}) + ONE_QUANTUM;
  endfunction : field_plus_one

  function automatic logic majority3(input logic a, input logic b, input logic c);
    majority3 = (a & b) | (a & c) | (b & c);
  endfunction : majority3

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  cbt_segments_s seg_cfg_ff;
  cbt_segments_s nxt_seg_cfg;
  cbt_presc_s presc_cfg_ff;
  cbt_presc_s nxt_presc_cfg;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  always_comb begin
    nxt_seg_cfg = seg_cfg_ff;
    nxt_presc_cfg = presc_cfg_ff;
    if (reg_req.wr && reg_req.addr == ADDR_SEGMENTS) begin
      nxt_seg_cfg = cbt_segments_s'(reg_req.wdata);
    end else if (reg_req.wr && reg_req.addr == ADDR_PRESCALE_JUMP) begin
      nxt_presc_cfg = cbt_presc_s'(reg_req.wdata);
    end
    // Read data follows the address every cycle and shows the stored value.
    if (reg_req.addr == ADDR_SEGMENTS) begin
      nxt_rdata = DATA_W'(seg_cfg_ff);
    end else if (reg_req.addr == ADDR_PRESCALE_JUMP) begin
      nxt_rdata = DATA_W'(presc_cfg_ff);
    end else begin
      nxt_rdata = READ_UNMAPPED;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seg_cfg_ff <= cbt_segments_s'(REG_RESET);
      presc_cfg_ff <= cbt_presc_s'(REG_RESET);
      rdata_ff <= REG_RESET;
    end else begin
      seg_cfg_ff <= nxt_seg_cfg;
      presc_cfg_ff <= nxt_presc_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Quantum generation and segment lengths.

  logic tq_tick;

  cbt_quantum_gen #(
    .PRESC_W(PRESC_W)
  ) u_quantum_gen (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .quantum_prescaler(presc_cfg_ff.quantum_prescaler),
    .tq_tick(tq_tick)
  );

  logic [QCNT_W-1:0] prop_len;
  logic [QCNT_W-1:0] ph1_len;
  logic [QCNT_W-1:0] ph2_len;
  logic [QCNT_W-1:0] jump_len;

  assign prop_len = field_plus_one(seg_cfg_ff.propagation_length_field);
  assign ph1_len = field_plus_one(seg_cfg_ff.phase1_length_field);
  assign jump_len = QCNT_W'({1'b0, presc_cfg_ff.resync_jump_width}) + ONE_QUANTUM;
  assign ph2_len = seg_cfg_ff.phase2_length_select
                 ? field_plus_one(phase2_length_field)
                 : max_q(ph1_len, INFO_PROCESSING_TIME);

  //////////////////////////////////////////////////////////////////////////////
  // Segment sequencer with resynchronisation and sampling.

  cbt_seg_e seg_ff;
  cbt_seg_e nxt_seg;
  logic [QCNT_W-1:0] left_ff;
  logic [QCNT_W-1:0] nxt_left;
  logic [QCNT_W-1:0] elapsed_ff;
  logic [QCNT_W-1:0] nxt_elapsed;
  logic resynced_ff;
  logic nxt_resynced;
  logic rx_prev_ff;
  logic [1:0] early_ff;
  logic [1:0] nxt_early;
  logic rx_bit_ff;
  logic nxt_rx_bit;
  logic sample_ff;
  logic nxt_sample;
  logic start_ff;
  logic nxt_start;
  logic tq_out_ff;
  logic fall_edge;
  logic edge_pend_ff;
  logic nxt_edge_pend;
  logic edge_hit;

  assign fall_edge = rx_prev_ff & ~rx_level;
  // An edge that meets a quantum tick is held one clock, so that the tick is never lost.
  assign edge_hit = (fall_edge || edge_pend_ff) && !tq_tick;

  always_comb begin
    nxt_seg = seg_ff;
    nxt_left = left_ff;
    nxt_elapsed = elapsed_ff;
    nxt_resynced = resynced_ff;
    nxt_early = early_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_sample = 1'b0;
    nxt_start = 1'b0;
    nxt_edge_pend = fall_edge && tq_tick;
    // Edge adjustments act on the first clock without a tick; one adjustment per bit.
    if (edge_hit && !resynced_ff) begin
      case (seg_ff)
        SEG_PROP, SEG_PH1: begin
          // Late edge: stretch phase 1 by the phase error, capped at jump width.
          nxt_resynced = 1'b1;
          if (seg_ff == SEG_PH1) begin
            nxt_left = left_ff + min_q(elapsed_ff, jump_len);
          end else begin
            nxt_elapsed = elapsed_ff + min_q(elapsed_ff, jump_len);
          end
        end
        SEG_PH2: begin
          // Early edge: cut phase 2 short by no more than the jump width.
          nxt_resynced = 1'b1;
          if (left_ff <= jump_len) begin
            nxt_seg = SEG_SYNC;
            nxt_left = SYNC_QUANTA;
            nxt_start = 1'b1;
          end else begin
            nxt_left = left_ff - jump_len;
          end
        end
        default: begin
          nxt_resynced = resynced_ff;
        end
      endcase
    end else if (tq_tick) begin
      nxt_elapsed = elapsed_ff + ONE_QUANTUM;
      if (left_ff > ONE_QUANTUM) begin
        nxt_left = left_ff - ONE_QUANTUM;
      end else begin
        case (seg_ff)
          SEG_SYNC: begin
            nxt_seg = SEG_PROP;
            nxt_left = prop_len;
            nxt_elapsed = '0;
          end
          SEG_PROP: begin
            nxt_seg = SEG_PH1;
            // A late edge seen during propagation lengthens phase 1 here.
            nxt_left = ph1_len + (elapsed_ff > prop_len ? elapsed_ff - prop_len : '0);
          end
          SEG_PH1: begin
            nxt_seg = SEG_PH2;
            nxt_left = ph2_len;
            nxt_sample = 1'b1;
            nxt_rx_bit = seg_cfg_ff.triple_sample_select
                       ? majority3(early_ff[1], early_ff[0], rx_level)
                       : rx_level;
          end
          default: begin
            nxt_seg = SEG_SYNC;
            nxt_left = SYNC_QUANTA;
            nxt_resynced = 1'b0;
            nxt_start = 1'b1;
          end
        endcase
      end
      // Two quanta-spaced samples ahead of the sample point feed the vote.
      nxt_early = {early_ff[0], rx_level};
    end
    if (nxt_start) begin
      nxt_resynced = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seg_ff <= SEG_SYNC;
      left_ff <= SYNC_QUANTA;
      elapsed_ff <= '0;
      resynced_ff <= 1'b0;
      rx_prev_ff <= 1'b1;
      edge_pend_ff <= 1'b0;
      early_ff <= 2'h3;
      rx_bit_ff <= 1'b1;
      sample_ff <= 1'b0;
      start_ff <= 1'b0;
      tq_out_ff <= 1'b0;
    end else begin
      seg_ff <= nxt_seg;
      left_ff <= nxt_left;
      elapsed_ff <= nxt_elapsed;
      resynced_ff <= nxt_resynced;
      rx_prev_ff <= rx_level;
      edge_pend_ff <= nxt_edge_pend;
      early_ff <= nxt_early;
      rx_bit_ff <= nxt_rx_bit;
      sample_ff <= nxt_sample;
      start_ff <= nxt_start;
      tq_out_ff <= tq_tick;
    end
  end

  assign tq_pulse = tq_out_ff;
  assign bit_start = start_ff;
  assign sample_pulse = sample_ff;
  assign rx_bit = rx_bit_ff;
  assign seg_state = seg_ff;

endmodule : cbt_bit_timing

// *** rtl/cbt_pkg.sv ***
/*
  Constants, register layouts and state codes for the CAN bit timing block.
  Assumes a single system clock; the register port is a plain 8-bit address/data port.
*/
package cbt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PRESC_W = 6;
  localparam int SEG_W = 3;
  localparam int JUMP_W = 2;
  localparam int QCNT_W = 5;

  localparam logic [ADDR_W-1:0] ADDR_SEGMENTS = 8'h29;
  localparam logic [ADDR_W-1:0] ADDR_PRESCALE_JUMP = 8'h2a;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

  // Information processing time, in quanta.
  localparam logic [QCNT_W-1:0] INFO_PROCESSING_TIME = 5'h02;
  localparam logic [QCNT_W-1:0] SYNC_QUANTA = 5'h01;
  localparam logic [QCNT_W-1:0] ONE_QUANTUM = 5'h01;

  typedef struct packed {
    logic phase2_length_select;
    logic triple_sample_select;
    logic [SEG_W-1:0] phase1_length_field;
    logic [SEG_W-1:0] propagation_length_field;
  } cbt_segments_s;

  typedef struct packed {
    logic [JUMP_W-1:0] resync_jump_width;
    logic [PRESC_W-1:0] quantum_prescaler;
  } cbt_presc_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic [DATA_W-1:0] wdata;
  } cbt_reg_req_s;

  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_PROP = 2'b01,
    SEG_PH1 = 2'b10,
    SEG_PH2 = 2'b11
  } cbt_seg_e;

endpackage : cbt_pkg

// *** rtl/cbt_quantum_gen.sv ***
/*
  Time quantum generator: one-cycle tick every 2 x (prescaler + 1) clocks.
  Assumes the prescaler value is stable or that a change may stretch one quantum.
*/
`timescale 1ns/1ps
module cbt_quantum_gen #(
  parameter int PRESC_W = 6
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [PRESC_W-1:0] quantum_prescaler,
  output logic tq_tick
);
  import cbt_pkg::*;

  logic [PRESC_W:0] cnt_ff;
  logic [PRESC_W:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;
  logic [PRESC_W:0] last_count;

  // Terminal count is 2 x (prescaler + 1) - 1 = 2 x prescaler + 1.
  assign last_count = {quantum_prescaler, 1'b1};

  always_comb begin
    nxt_tick = 1'b0;
    nxt_cnt = cnt_ff + 1'b1;
    if (cnt_ff >= last_count) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tq_tick = tick_ff;

endmodule : cbt_quantum_gen

// *** tb/cbt_bit_timing_tb_top.sv ***
/* Testbench for the bit timing block.
   Drives registers and a bus node model; expected values worked by hand. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module cbt_bit_timing_tb_top;
  import cbt_pkg::*;
  typedef struct packed {
    logic [7:0] pj;
    logic [7:0] sg;
    logic [2:0] f2;
    logic [7:0] len;
  } cbt_row_s;
  logic clk_sys, resetn, rx_level, node_dom, tq_pulse, bit_start, sample_pulse, rx_bit;
  logic [2:0] p2f;
  logic [7:0] reg_rdata, cyc;
  cbt_reg_req_s req;
  cbt_seg_e seg_state;
  int err_count, checks_done;
  // Rows: prescale/jump, segments, phase-2 field, bit length in clocks.
  cbt_row_s rows [4] = '{'{8'h00, 8'h00, 3'h0, 8'h0a}, '{8'h41, 8'h5a, 3'h0, 8'h30},
    '{8'h82, 8'h89, 3'h4, 8'h3c}, '{8'hc0, 8'hff, 3'h7, 8'h32}};
  cbt_bit_timing uut (.clk_sys, .resetn, .reg_req(req), .reg_rdata,
    .phase2_length_field(p2f), .rx_level, .tq_pulse, .bit_start, .sample_pulse, .rx_bit,
    .seg_state);
  cbt_can_node node (.clk_sys, .resetn, .node_dom, .rx_level);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= bit_start ? 8'h01 : cyc + 8'h01;
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{a, 1'b1, d};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    req.addr <= a;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask : rd
  task automatic wbs;
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      #1;
      i++;
    end while (bit_start !== 1'b1 && i < 400);
    `CHK("bit_start", 1'b1, bit_start)
  endtask : wbs
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // The whole run needs about 10 us; this is ten times that.
  initial begin
    #100000;
    err_count++;
    final_report();
  end
  initial begin
    {resetn, node_dom, p2f, err_count, checks_done} = '0;
    req = '0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(ADDR_SEGMENTS, REG_RESET);
    rd(ADDR_PRESCALE_JUMP, REG_RESET);
    wr(8'h2b, 8'hff);
    rd(8'h2b, READ_UNMAPPED);
    rd(ADDR_SEGMENTS, REG_RESET);
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk_sys);
      p2f <= rows[i].f2;
      wr(ADDR_PRESCALE_JUMP, rows[i].pj);
      wr(ADDR_SEGMENTS, rows[i].sg);
      rd(ADDR_PRESCALE_JUMP, rows[i].pj);
      rd(ADDR_SEGMENTS, rows[i].sg);
      wbs();
      wbs();
      `CHK("bit_len", rows[i].len, cyc)
      `CHK("rx_bit", 1'b1, rx_bit)
      $display("test row %0d done", i);
    end
    // An edge early in phase 2 shortens the bit by the jump width.
    for (int j = 0; j < 4; j++) begin
      wr(ADDR_PRESCALE_JUMP, {2'(j), 6'h00});
      wr(ADDR_SEGMENTS, j[0] ? 8'h7f : 8'h3f);
      wbs();
      wbs();
      for (int k = 0; k < 100 && seg_state !== SEG_PH2; k++) begin
        @(posedge clk_sys);
        #1;
      end
      `CHK("seg_state", SEG_PH2, seg_state)
      @(posedge clk_sys);
      node_dom <= 1'b1;
      wbs();
      `CHK("short_bit", 8'h30 - 8'(j) * 8'h02, cyc)
      wbs();
      wbs();
      `CHK("rx_bit", 1'b0, rx_bit)
      @(posedge clk_sys);
      node_dom <= 1'b0;
      wbs();
      wbs();
      `CHK("rx_bit", 1'b1, rx_bit)
      $display("test jump %0d done", j);
    end
    // A reset in mid-run clears both registers and restarts bit timing.
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("seg_reset", SEG_SYNC, seg_state)
    `CHK("rx_bit_reset", 1'b1, rx_bit)
    @(posedge clk_sys);
    resetn <= 1'b1;
    rd(ADDR_SEGMENTS, REG_RESET);
    rd(ADDR_PRESCALE_JUMP, REG_RESET);
    wbs();
    wbs();
    `CHK("bit_len_reset", 8'h0a, cyc)
    $display("test mid reset done");
    final_report();
  end
endmodule : cbt_bit_timing_tb_top

// *** tb/cbt_can_node.sv ***
/* Other nodes on the CAN bus.
   Bus is recessive unless node_dom pulls it dominant. */
`timescale 1ns/1ps
module cbt_can_node (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic node_dom,
  output logic rx_level
);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) rx_level <= 1'b1;
    else rx_level <= !node_dom;
  end
endmodule : cbt_can_node

// *** tb/cbt_chk.sv ***
/* Assertions on the bit timing block.
   Bound to the top module; sees only its ports. */
`timescale 1ns/1ps
module cbt_chk #(
  parameter int PRESC_W = 6
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire cbt_pkg::cbt_reg_req_s reg_req,
  input wire logic [cbt_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [cbt_pkg::SEG_W-1:0] phase2_length_field,
  input wire logic rx_level,
  input wire logic tq_pulse,
  input wire logic bit_start,
  input wire logic sample_pulse,
  input wire logic rx_bit,
  input wire cbt_pkg::cbt_seg_e seg_state
);
  import cbt_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [7:0] s29_ff, s2a_ff, qc_ff, rd, ql;
  logic [3:0] qn_ff, p2;
  logic [1:0] cq_ff, hv_ff;
  logic [2:0] pf_ff;
  logic wf_ff, ef_ff, rx_ff, ex;
  cbt_seg_e sq_ff;
  always_comb rd = reg_req.addr == ADDR_SEGMENTS ? s29_ff :
    reg_req.addr == ADDR_PRESCALE_JUMP ? s2a_ff : READ_UNMAPPED;
  always_comb p2 = s29_ff[7] ? 4'(phase2_length_field) + 4'h1 :
    s29_ff[5:3] == 3'h0 ? 4'h2 : 4'(s29_ff[5:3]) + 4'h1;
  always_comb ql = {1'b0, s2a_ff[5:0], 1'b0} + 8'h02;
  always_comb ex = seg_state != sq_ff && !wf_ff && phase2_length_field == pf_ff;
  // Length checks are skipped for a bit in which the registers or the phase-2 field moved.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {s29_ff, s2a_ff, qc_ff, qn_ff, ef_ff, pf_ff} <= '0;
      {cq_ff, wf_ff, rx_ff, hv_ff} <= '1;
      sq_ff <= SEG_SYNC;
    end else begin
      if (reg_req.wr && reg_req.addr == ADDR_SEGMENTS) s29_ff <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == ADDR_PRESCALE_JUMP) s2a_ff <= reg_req.wdata;
      qc_ff <= tq_pulse ? 8'h01 : qc_ff + 8'h01;
      qn_ff <= seg_state != sq_ff ? 4'h0 : qn_ff + 4'(tq_pulse);
      sq_ff <= seg_state;
      rx_ff <= rx_level;
      pf_ff <= phase2_length_field;
      if (tq_pulse) hv_ff <= {hv_ff[0], rx_ff};
      cq_ff <= reg_req.wr ? 2'h3 : cq_ff - 2'(tq_pulse && cq_ff != 2'h0);
      wf_ff <= reg_req.wr || phase2_length_field != pf_ff || (wf_ff && !bit_start);
      ef_ff <= (rx_ff && !rx_level) || (ef_ff && !bit_start);
    end
  end
  ////////////////////////////////////////
  rd_data_a: assert property (reg_rdata == $past(rd))
    else $error("read data wrong");
  quantum_len_a: assert property (tq_pulse && cq_ff == 2'h0 |-> qc_ff == ql)
    else $error("quantum length wrong");
  seg_order_a: assert property ($changed(seg_state) |->
    2'(seg_state - $past(seg_state)) == 2'h1) else $error("segment order wrong");
  sample_point_a: assert property (sample_pulse ==
    ($changed(seg_state) && seg_state == SEG_PH2)) else $error("sample point wrong");
  rx_hold_a: assert property (!sample_pulse |-> $stable(rx_bit))
    else $error("rx_bit moved off sample");
  prop_len_a: assert property (ex && sq_ff == SEG_PROP |->
    qn_ff == 4'(s29_ff[2:0])) else $error("prop length wrong");
  ph1_len_a: assert property (ex && !ef_ff && sq_ff == SEG_PH1 |->
    qn_ff == 4'(s29_ff[5:3])) else $error("phase 1 length wrong");
  ph2_len_a: assert property (ex && !ef_ff && sq_ff == SEG_PH2 |->
    qn_ff + 4'h1 == p2) else $error("phase 2 length wrong");
  ph1_max_a: assert property (ex && sq_ff == SEG_PH1 |->
    qn_ff <= 4'(s29_ff[5:3]) + 4'(s2a_ff[7:6]) + 4'h1) else $error("phase 1 too long");
  ph2_min_a: assert property (ex && sq_ff == SEG_PH2 |->
    qn_ff + 4'(s2a_ff[7:6]) + 4'h2 >= p2) else $error("phase 2 too short");
  rx_vote_a: assert property (sample_pulse |-> rx_bit == ($past(s29_ff[6]) ?
    ((hv_ff[1] & hv_ff[0]) | (hv_ff[1] & rx_ff) | (hv_ff[0] & rx_ff)) : rx_ff))
    else $error("sampled bit wrong");
endmodule : cbt_chk

bind cbt_bit_timing cbt_chk #(.PRESC_W(PRESC_W)) chk_i (.clk_sys, .resetn, .reg_req,
  .reg_rdata, .phase2_length_field, .rx_level, .tq_pulse, .bit_start, .sample_pulse,
  .rx_bit, .seg_state);
